// File: dlc_top.sv
// link, chain and completion interrupt sequencer of the dma controller
//
// Function
// - link bit set: load linked entry, run it on the next trigger
// - follow links until link bit clear
// - self link reloads same set, restarts
// - linked entries share channel's one event
// - narrow variant: only channels 8-11 chain
// - wide variant: all 64 chain, 6-bit codes
// - channels and quick set report codes
// - wide variant: alternate code triggers after intermediate transfers
// - alternate skipped for 2-D block; final wins
// - trigger needs code and report bit set
// - chain enable bit gates each code
// - pending bit index equals completion code
// - shared irq when enabled code received
// - pending sticky, write one clears
// - identical codes from many sources OR together
`timescale 1ns/10ps
`include "dlc_defs.svh"
module dlc_top #(
  parameter int NCH  = 64,   // 16 or 64 channels
  parameter int NENT = 128,  // parameter memory entries
  parameter int CW   = (NCH > 16) ? 6 : 4,
  parameter int EW   = $clog2(NENT),
  parameter int IW   = $clog2(NCH)
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic                  pready,
  output logic [31:0]           prdata,
  output logic                  pslverr,
  // channel sync event pins
  input  wire logic [NCH-1:0]   evt_in,
  // submission to the transfer logic
  output logic                  xfer_valid,
  input  wire logic             xfer_ready,
  output logic [IW-1:0]         xfer_chan,
  output logic [31:0]           xfer_entry,
  // shared completion interrupt
  output logic                  completion_irq
);
  // ============================================================
  // declarations
  localparam bit WIDE = (NCH > 16);
  logic [NCH-1:0]   pend_r;             // irq_pending_reg
  logic [NCH-1:0]   ien_r;              // irq_enable_reg
  logic [NCH-1:0]   cen_r;              // chain_enable_reg
  logic [NCH-1:0]   een_r;              // event enable
  logic [NCH-1:0]   armed_r;            // channel holds a live entry
  logic [NCH-1:0]   evt_pend_r;         // trigger waiting for service
  logic [NCH-1:0]   sync1_r, sync2_r;   // pin synchroniser
  logic [NCH-1:0]   sync3_r;            // edge detect history
  logic [31:0]      pmem_r [NENT];      // parameter_memory
  logic [EW-1:0]    cur_r  [NCH];       // current entry per channel
  logic [7:0]       rem_r  [NCH];       // submissions left in entry
  logic [IW-1:0]    sel_r;              // channel in service
  logic [31:0]      ent_r;              // entry word in service
  logic [31:0]      prdata_r;           // read data, captured in setup
  logic             pslverr_r;          // error, captured in setup
  dlc_pkg::dlc_state_t st_r;            // sequencer state
  logic [NCH-1:0]   cap_mask;           // chain capable channels
  logic [NCH-1:0]   pend_set_w;         // regular and quick reports
  logic [NCH-1:0]   alt_set_w;          // alternate reports
  logic [NCH-1:0]   chain_hit;          // enabled chain triggers
  logic [NCH-1:0]   ev_trig;            // synced event edges
  logic [NCH-1:0]   man_w, arm_w, pclr_w;
  logic [63:0]      pend64, ien64;      // lo/hi word views
  logic [63:0]      cen64, een64, arm64; // lo/hi word views
  logic [NCH-1:0]   issue_clr;
  logic             pick_vld;
  logic [IW-1:0]    pick_idx;
  logic             wr_acc, rd_setup;
  logic             last_w;
  logic [EW-1:0]    link_w;

  // ============================================================
  // helpers
  // count field, zero taken as one submission
  function automatic logic [7:0] cnt_of(input logic [31:0] w);
    cnt_of = (w[`DLC_F_CNT_LSB +: 8] == 8'h00) ? 8'h01
                                                : w[`DLC_F_CNT_LSB +: 8];
  endfunction
  // widen a channel vector to 64 bits for the lo/hi words
  function automatic logic [63:0] pad64(input logic [NCH-1:0] v);
    pad64 = `DLC_RST_VEC;
    pad64[NCH-1:0] = v;
  endfunction
  // one code to a one-hot channel vector, only the low CW bits of the code used
  function automatic logic [NCH-1:0] dec(input logic [5:0] c);
    dec = '0;
    if (32'(c[CW-1:0]) < NCH) dec[c[CW-1:0]] = 1'b1;
  endfunction

  // ============================================================
  // apb decode
  // zero wait: every access answers in its first access cycle
  assign pready   = 1'b1;
  assign prdata   = prdata_r;
  assign pslverr  = pslverr_r;
  assign wr_acc   = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  // 64-bit views, so narrow parts read zero in the upper word
  assign pend64   = pad64(pend_r);
  assign ien64    = pad64(ien_r);
  assign cen64    = pad64(cen_r);
  assign een64    = pad64(een_r);
  assign arm64    = pad64(armed_r);

  // write strobes for the lo/hi pairs, one-cycle pulses
  always_comb begin
    logic [63:0] m;
    m = `DLC_RST_VEC;
    if (wr_acc && paddr[2]) m[63:32] = pwdata;
    else if (wr_acc) m[31:0] = pwdata;
    pclr_w = '0;
    man_w  = '0;
    arm_w  = '0;
    if ({paddr[11:3], 3'b000} == `DLC_OFF_PEND_LO) pclr_w = m[NCH-1:0];
    if ({paddr[11:3], 3'b000} == `DLC_OFF_MAN_LO)  man_w  = m[NCH-1:0];
    if ({paddr[11:3], 3'b000} == `DLC_OFF_ARM_LO)  arm_w  = m[NCH-1:0];
  end

  // read mux sampled in the setup cycle, so data leaves a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= `DLC_RST_WORD;
      pslverr_r <= 1'b0;
    end else if (rd_setup) begin
      pslverr_r <= 1'b0;
      case ({paddr[11:3], 3'b000})
        `DLC_OFF_PEND_LO: prdata_r <= paddr[2] ? pend64[63:32]
                                               : pend64[31:0];
        `DLC_OFF_IEN_LO:  prdata_r <= paddr[2] ? ien64[63:32]
                                               : ien64[31:0];
        `DLC_OFF_CEN_LO:  prdata_r <= paddr[2] ? cen64[63:32]
                                               : cen64[31:0];
        `DLC_OFF_EEN_LO:  prdata_r <= paddr[2] ? een64[63:32]
                                               : een64[31:0];
        `DLC_OFF_ARM_LO:  prdata_r <= paddr[2] ? arm64[63:32]
                                               : arm64[31:0];
        `DLC_OFF_MAN_LO:  prdata_r <= `DLC_RST_WORD;
        `DLC_OFF_QUICK: begin
          // status sits in the upper word of this pair
          prdata_r <= paddr[2] ? {23'h0, st_r != dlc_pkg::DLC_IDLE,
                                  2'b00, 6'(sel_r)} : `DLC_RST_WORD;
        end
        default: begin
          if (paddr >= `DLC_OFF_PMEM &&
              32'(paddr - `DLC_OFF_PMEM) < 4 * NENT) begin
            prdata_r <= pmem_r[paddr[EW+1:2]];
          end else begin
            // unmapped: zero data; only a read answers with an error
            prdata_r  <= `DLC_RST_WORD;
            pslverr_r <= ~pwrite;
          end
        end
      endcase
    end
  end

  // ============================================================
  // plain control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_r <= '0;
      cen_r <= '0;
      een_r <= '0;
    end else if (wr_acc) begin
      case (paddr)
        `DLC_OFF_IEN_LO: ien_r <= NCH'({ien64[63:32], pwdata});
        `DLC_OFF_IEN_HI: if (WIDE) ien_r <= NCH'({pwdata, ien64[31:0]});
        `DLC_OFF_CEN_LO: cen_r <= NCH'({cen64[63:32], pwdata});
        `DLC_OFF_CEN_HI: if (WIDE) cen_r <= NCH'({pwdata, cen64[31:0]});
        `DLC_OFF_EEN_LO: een_r <= NCH'({een64[63:32], pwdata});
        `DLC_OFF_EEN_HI: if (WIDE) een_r <= NCH'({pwdata, een64[31:0]});
        default: ;  // other offsets handled elsewhere
      endcase
    end
  end

  // parameter memory, software writes only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NENT; i++) pmem_r[i] <= `DLC_RST_WORD;
    end else if (wr_acc && paddr >= `DLC_OFF_PMEM &&
                 32'(paddr - `DLC_OFF_PMEM) < 4 * NENT) begin
      pmem_r[paddr[EW+1:2]] <= pwdata;
    end
  end

  // ============================================================
  // event pins: two flops, then rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else begin
      sync1_r <= evt_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end
  assign ev_trig = sync2_r & ~sync3_r & een_r;

  // ============================================================
  // completion reports and chain triggers
  // narrow part: only channels 8..11 chain; wide: all of them
  assign cap_mask = WIDE ? '1 : NCH'(16'h0F00);
  assign last_w   = (rem_r[sel_r] <= 8'h01);
  assign link_w   = ent_r[`DLC_F_LINK_LSB +: EW];

  // reports merge by OR, code chooses the bit, not the channel
  always_comb begin
    pend_set_w = '0;
    alt_set_w  = '0;
    if (st_r == dlc_pkg::DLC_DONE && last_w && ent_r[`DLC_F_REP]) begin
      pend_set_w = dec(ent_r[`DLC_F_CODE_LSB +: 6]);
    end
    // alternate only between transfers, never for 2-D block sync
    if (WIDE && st_r == dlc_pkg::DLC_DONE && !last_w &&
        ent_r[`DLC_F_ALT_REP] && !ent_r[`DLC_F_BLK2D]) begin
      alt_set_w = dec(ent_r[`DLC_F_ALT_LSB +: 6]);
    end
    // quick request set reports through its own write
    if (wr_acc && paddr == `DLC_OFF_QUICK && pwdata[`DLC_F_REP]) begin
      pend_set_w = pend_set_w | dec(pwdata[5:0]);
    end
  end

  // chain enable gates every code; unchained codes trigger no channel
  assign chain_hit = (pend_set_w | alt_set_w) & cen_r & cap_mask;

  // ============================================================
  // pending bits and the shared interrupt
  // a report in the clearing cycle keeps the bit set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pend_r <= '0;
    else pend_r <= (pend_r & ~pclr_w) | pend_set_w;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) completion_irq <= 1'b0;
    else completion_irq <= |(((pend_r & ~pclr_w) | pend_set_w) &
                             ien_r);
  end

  // ============================================================
  // trigger latches: pin event, chain or manual, one per channel
  // all entries of a channel consume this same latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) evt_pend_r <= '0;
    else evt_pend_r <= (evt_pend_r & ~issue_clr) |
                       ev_trig | chain_hit | man_w;
  end

  dlc_prio #(.N(NCH), .IW(IW)) dlc_prio_i (
    .req (evt_pend_r & armed_r),
    .vld (pick_vld),
    .idx (pick_idx)
  );
  always_comb begin
    issue_clr = '0;
    if (st_r == dlc_pkg::DLC_IDLE && pick_vld) issue_clr[pick_idx] = 1'b1;
  end

  // ============================================================
  // sequencer: pick, submit, then finish the entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r  <= dlc_pkg::DLC_IDLE;
      sel_r <= '0;
      ent_r <= `DLC_RST_WORD;
    end else begin
      case (st_r)
        dlc_pkg::DLC_IDLE: begin
          if (pick_vld) begin
            sel_r <= pick_idx;
            ent_r <= pmem_r[cur_r[pick_idx]];
            st_r  <= dlc_pkg::DLC_ISSUE;
          end
        end
        // request held stable until the transfer logic takes it
        dlc_pkg::DLC_ISSUE: if (xfer_ready) st_r <= dlc_pkg::DLC_DONE;
        dlc_pkg::DLC_DONE:  st_r <= dlc_pkg::DLC_IDLE;
        default:            st_r <= dlc_pkg::DLC_IDLE;
      endcase
    end
  end
  assign xfer_valid = (st_r == dlc_pkg::DLC_ISSUE);
  assign xfer_chan  = sel_r;
  assign xfer_entry = ent_r;

  // per-channel entry pointer, remaining count and armed flag
  // arming reloads the channel's home entry, index = channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_r <= '0;
      for (int c = 0; c < NCH; c++) begin
        cur_r[c] <= '0;
        rem_r[c] <= 8'h00;
      end
    end else begin
      if (st_r == dlc_pkg::DLC_DONE) begin
        if (!last_w) begin
          rem_r[sel_r] <= rem_r[sel_r] - 8'h01;
        end else if (ent_r[`DLC_F_LINK_EN]) begin
          // load the linked set; a self link restarts it
          cur_r[sel_r] <= link_w;
          rem_r[sel_r] <= cnt_of(pmem_r[link_w]);
        end else begin
          armed_r[sel_r] <= 1'b0;
        end
      end
      for (int c = 0; c < NCH; c++) begin
        if (arm_w[c]) begin
          armed_r[c] <= 1'b1;
          cur_r[c]   <= EW'(c);
          rem_r[c]   <= cnt_of(pmem_r[c]);
        end
      end
    end
  end

  // ============================================================
  // checks
  pend_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    pend_set_w != '0 |=> (pend_r & $past(pend_set_w)) == $past(pend_set_w))
    else $error("reported code did not set its pending bit");
  irq_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pend_set_w & ien_r) != '0 |=> completion_irq)
    else $error("enabled code did not raise the interrupt");
  link_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == dlc_pkg::DLC_DONE && last_w && ent_r[`DLC_F_LINK_EN]
      && arm_w == '0 |=> cur_r[$past(sel_r)] == $past(link_w))
    else $error("linked entry was not loaded");
  list_end_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == dlc_pkg::DLC_DONE && last_w && !ent_r[`DLC_F_LINK_EN]
      && arm_w == '0 |=> !armed_r[$past(sel_r)])
    else $error("channel stayed armed after last entry");
  chain_trig_a: assert property (@(posedge pclk) disable iff (!presetn)
    chain_hit != '0 |=> (evt_pend_r & $past(chain_hit)) == $past(chain_hit))
    else $error("chain trigger was lost");
  // a new trigger bit must come from a pin, a manual write or an
  // enabled chain-capable channel
  chain_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> (evt_pend_r & ~$past(evt_pend_r | ev_trig | man_w)
              & ~$past(cen_r & cap_mask)) == '0)
    else $error("chain trigger reached a disabled channel");
  alt_final_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == dlc_pkg::DLC_DONE && (last_w || ent_r[`DLC_F_BLK2D])
      |-> alt_set_w == '0)
    else $error("alternate chain fired on a final or block transfer");
  issue_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    xfer_valid && !xfer_ready |=> xfer_valid && $stable(xfer_entry)
      && $stable(xfer_chan))
    else $error("submission changed before it was taken");
  link_c: cover property (@(posedge pclk) disable iff (!presetn)
    st_r == dlc_pkg::DLC_DONE && last_w && ent_r[`DLC_F_LINK_EN]);
  chain_c: cover property (@(posedge pclk) disable iff (!presetn)
    chain_hit != '0);
  irq_c: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(completion_irq));
endmodule

// File: dlc_defs.svh
// register offsets, field positions and reset values of the chain block
`ifndef DLC_DEFS_SVH
`define DLC_DEFS_SVH

// ============================================================
// register byte offsets
`define DLC_OFF_PEND_LO  12'h000
`define DLC_OFF_PEND_HI  12'h004
`define DLC_OFF_IEN_LO   12'h008
`define DLC_OFF_IEN_HI   12'h00C
`define DLC_OFF_CEN_LO   12'h010
`define DLC_OFF_CEN_HI   12'h014
`define DLC_OFF_EEN_LO   12'h018
`define DLC_OFF_EEN_HI   12'h01C
`define DLC_OFF_ARM_LO   12'h020
`define DLC_OFF_ARM_HI   12'h024
`define DLC_OFF_MAN_LO   12'h028
`define DLC_OFF_MAN_HI   12'h02C
`define DLC_OFF_QUICK    12'h030
`define DLC_OFF_STATUS   12'h034
`define DLC_OFF_PMEM     12'h400

// ============================================================
// parameter memory entry word fields
`define DLC_F_CODE_LSB   0
`define DLC_F_REP        6
`define DLC_F_ALT_LSB    7
`define DLC_F_ALT_REP    13
`define DLC_F_LINK_EN    14
`define DLC_F_BLK2D      15
`define DLC_F_LINK_LSB   16
`define DLC_F_CNT_LSB    24

// ============================================================
// reset values
`define DLC_RST_WORD     32'h0000_0000
`define DLC_RST_VEC      64'h0000_0000_0000_0000

`endif

// File: dlc_pkg.sv
// types shared by the chain completion block
package dlc_pkg;
  // sequencer states, one-hot
  typedef enum logic [2:0] {
    DLC_IDLE  = 3'b001,
    DLC_ISSUE = 3'b010,
    DLC_DONE  = 3'b100
  } dlc_state_t;
endpackage

// File: dlc_prio.sv
// lowest-index-first picker over a request vector
`timescale 1ns/10ps
module dlc_prio #(
  parameter int N  = 64,
  parameter int IW = 6
) (
  // requests
  input  wire logic [N-1:0]  req,
  // result
  output logic               vld,
  output logic [IW-1:0]      idx
);
  // scan downward so the lowest set bit wins
  always_comb begin
    vld = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        vld = 1'b1;
        idx = IW'(i);
      end
    end
  end
endmodule

// File: dlc_xfer_model.sv
// transfer logic stand-in that accepts submissions and logs them
`timescale 1ns/10ps
module dlc_xfer_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // submission from the sequencer
  input  wire logic        xfer_valid,
  output logic             xfer_ready,
  input  wire logic [5:0]  xfer_chan,
  input  wire logic [31:0] xfer_entry,
  // stall request and log
  input  wire logic        stall,
  output logic [15:0]      n_taken,
  output logic [5:0]       last_chan,
  output logic [31:0]      last_entry
);
  // ============================================================
  // ready
  // ready lags stall by a cycle, like a queue that fills up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_ready <= 1'b0;
    end else begin
      xfer_ready <= ~stall;
    end
  end

  // ============================================================
  // log
  // a taken submission counts as completed, as the sequencer assumes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_taken    <= 16'h0000;
      last_chan  <= 6'h00;
      last_entry <= 32'h0000_0000;
    end else if (xfer_valid && xfer_ready) begin
      n_taken    <= n_taken + 16'h0001;
      last_chan  <= xfer_chan;
      last_entry <= xfer_entry;
    end
  end
endmodule

// File: dlc_top_bench.sv
// self-checking bench of the link, chain and completion sequencer
`timescale 1ns/10ps
`include "dlc_defs.svh"
module dlc_top_bench;
  // ============================================================
  // signals
  logic        pclk;            // 50 ns bus clock
  logic        presetn;         // reset, active low
  logic        psel;            // apb select
  logic        penable;         // apb access phase
  logic        pwrite;          // apb direction
  logic [11:0] paddr;           // apb address
  logic [31:0] pwdata;          // apb write data
  logic        pready;          // apb answer
  logic [31:0] prdata;          // apb read data
  logic        pslverr;         // apb error
  logic [63:0] evt_in;          // sync event pins
  logic        xfer_valid;      // submission offered
  logic        xfer_ready;      // submission taken
  logic [5:0]  xfer_chan;       // submitting channel
  logic [31:0] xfer_entry;      // submitted entry word
  logic        completion_irq;  // shared interrupt
  logic        stall;           // far side busy
  logic [15:0] n_taken;         // submissions so far
  logic [5:0]  last_chan;       // last channel taken
  logic [31:0] last_entry;      // last entry taken
  logic [15:0] rs;              // stall pattern state
  int          err_total;       // mismatches
  int          total_checks;    // comparisons
  int          cyc;             // watchdog count

  dlc_top dlc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .evt_in(evt_in),
    .xfer_valid(xfer_valid), .xfer_ready(xfer_ready),
    .xfer_chan(xfer_chan), .xfer_entry(xfer_entry),
    .completion_irq(completion_irq));
  dlc_xfer_model dlc_xfer_model_i (.pclk(pclk), .presetn(presetn),
    .xfer_valid(xfer_valid), .xfer_ready(xfer_ready),
    .xfer_chan(xfer_chan), .xfer_entry(xfer_entry), .stall(stall),
    .n_taken(n_taken), .last_chan(last_chan), .last_entry(last_entry));

  // ============================================================
  // clock, stall pattern, watchdog
  always #25 pclk = ~pclk;
  // random stalls so the sequencer must hold its offer
  always @(posedge pclk) begin
    rs    <= lfsr(rs);
    stall <= rs[0] & rs[3];
  end
  // a hang counts as a mismatch and ends the run
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      conclude();
    end
  end

  // ============================================================
  // helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // entry word: code, report, alt code, alt report, link, 2-d, link, count
  function automatic logic [31:0] ent(input logic [5:0] c, input logic r,
    input logic [5:0] ac, input logic ar, input logic lk, input logic b2,
    input logic [6:0] li, input logic [7:0] n);
    return {n, 1'b0, li, b2, lk, ar, ac, r, c};
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] wd, output logic [31:0] d, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr64(input logic [11:0] a, input logic [63:0] v);
    logic [31:0] d;
    logic        e;
    apb(1'b1, a, v[31:0], d, e);
    apb(1'b1, a + 12'h004, v[63:32], d, e);
  endtask
  task automatic rd64(input logic [11:0] a, output logic [63:0] v);
    logic e;
    apb(1'b0, a, 32'h0000_0000, v[31:0], e);
    apb(1'b0, a + 12'h004, 32'h0000_0000, v[63:32], e);
  endtask
  task automatic pm(input int i, input logic [31:0] w);
    logic [31:0] d;
    logic        e;
    apb(1'b1, `DLC_OFF_PMEM + 12'(4 * i), w, d, e);
  endtask
  // bounded wait for the far side to have taken n submissions
  task automatic wait_sub(input logic [15:0] n);
    for (int i = 0; i < 60 && n_taken !== n; i++) @(posedge pclk);
    repeat (4) @(posedge pclk);
    chk(n_taken, n);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ============================================================
  // main sequence
  initial begin
    logic [63:0] v;
    logic [63:0] ex;
    logic [31:0] d;
    logic        e;
    logic [15:0] s;
    logic [15:0] n;
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; evt_in = 0; stall = 0; rs = 16'h0014;
    err_total = 0; total_checks = 0; cyc = 0; s = 16'h0014; ex = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd64(`DLC_OFF_PEND_LO, v);
    chk(v, 64'h0);
    chk(completion_irq, 1'b0);
    apb(1'b0, 12'h038, 32'h0000_0000, d, e);
    chk({d, e}, {32'h0, 1'b1});
    // random quick reports, code 5 sent twice on purpose
    for (int k = 0; k < 10; k++) begin
      s = lfsr(s);
      if (k > 7) s[6:0] = 7'h45;
      apb(1'b1, `DLC_OFF_QUICK, {25'h0, s[6:0]}, d, e);
      if (s[6]) ex[s[5:0]] = 1'b1;
    end
    rd64(`DLC_OFF_PEND_LO, v);
    chk(v, ex);
    repeat (3) @(posedge pclk);
    chk(completion_irq, 1'b0);
    wr64(`DLC_OFF_IEN_LO, ex);
    repeat (3) @(posedge pclk);
    chk(completion_irq, 1'b1);
    wr64(`DLC_OFF_PEND_LO, ex);
    rd64(`DLC_OFF_PEND_LO, v);
    chk(v, 64'h0);
    repeat (3) @(posedge pclk);
    chk(completion_irq, 1'b0);
    // linked list on channel 2, one event per entry
    pm(2, ent(6'd40, 1, 0, 0, 1, 0, 7'd70, 0));
    pm(70, ent(6'd41, 1, 0, 0, 0, 0, 0, 0));
    wr64(`DLC_OFF_EEN_LO, 64'h4);
    wr64(`DLC_OFF_ARM_LO, 64'h4);
    n = n_taken;
    for (int k = 0; k < 3; k++) begin
      @(posedge pclk);
      evt_in <= 64'h4;
      repeat (4) @(posedge pclk);
      evt_in <= 64'h0;
      wait_sub(n + ((k < 2) ? 16'(k + 1) : 16'd2));
      if (k < 2) chk(last_entry, (k == 0) ? ent(6'd40, 1, 0, 0, 1, 0,
        7'd70, 0) : ent(6'd41, 1, 0, 0, 0, 0, 0, 0));
    end
    rd64(`DLC_OFF_PEND_LO, v);
    chk(v, 64'h0000_0300_0000_0000);
    // self link on channel 5 stays armed
    pm(5, ent(6'd5, 0, 0, 0, 1, 0, 7'd5, 0));
    wr64(`DLC_OFF_ARM_LO, 64'h20);
    for (int k = 1; k < 3; k++) begin
      wr64(`DLC_OFF_MAN_LO, 64'h20);
      wait_sub(n + 16'(k + 2));
      chk(last_chan, 6'd5);
    end
    // channel 63 walks its own list from one trigger
    pm(63, ent(6'd63, 1, 0, 0, 1, 0, 7'd71, 0));
    pm(71, ent(6'd63, 1, 0, 0, 0, 0, 0, 0));
    wr64(`DLC_OFF_CEN_LO, 64'h8000_0000_0000_0080);
    wr64(`DLC_OFF_ARM_LO, 64'h8000_0000_0000_0000);
    wr64(`DLC_OFF_MAN_LO, 64'h8000_0000_0000_0000);
    wait_sub(n + 16'd6);
    chk(last_entry, ent(6'd63, 1, 0, 0, 0, 0, 0, 0));
    // code 9 reported while chaining of 9 is off
    pm(4, ent(6'd9, 1, 0, 0, 0, 0, 0, 0));
    wr64(`DLC_OFF_ARM_LO, 64'h210);
    wr64(`DLC_OFF_MAN_LO, 64'h10);
    wait_sub(n + 16'd7);
    // alternate chain after the first of two submissions
    pm(6, ent(6'd0, 0, 6'd7, 1, 0, 0, 0, 8'd2));
    wr64(`DLC_OFF_ARM_LO, 64'hC0);
    wr64(`DLC_OFF_MAN_LO, 64'h40);
    wait_sub(n + 16'd9);
    chk(last_chan, 6'd7);
    // 2-d block entry never uses the alternate code
    pm(10, ent(6'd0, 0, 6'd7, 1, 0, 1, 0, 8'd2));
    wr64(`DLC_OFF_ARM_LO, 64'h480);
    wr64(`DLC_OFF_MAN_LO, 64'h400);
    wait_sub(n + 16'd10);
    chk(last_chan, 6'd10);
    conclude();
  end
endmodule
